//--- rtl/sfp_pkg.sv
// shared constants and carrier types for the flagged fifo bank
package sfp_pkg;
  // word width of every stored and read word
  localparam int SFP_DATA_W = 9;
  // buffer depth in words
  localparam int SFP_DEPTH = 8;
  // default almost-empty and almost-full offsets after reset
  localparam int SFP_AE_OFF_RST = 7;
  localparam int SFP_AF_OFF_RST = 7;
  // pin level at reset that selects dual write enable mode
  localparam logic SFP_MODE_DUAL = 1'b1;
  // offset pointer codes: which offset the next load or readback touches
  localparam logic SFP_SEL_AE = 1'b0;
  localparam logic SFP_SEL_AF = 1'b1;

  // programmed flag offsets, kept together
  typedef struct packed {
    logic [3:0] ae;
    logic [3:0] af;
  } sfp_offsets_t;

  // status flags, all active low as on the pins
  typedef struct packed {
    logic empty_n;
    logic almost_empty_n;
    logic full_n;
    logic almost_full_n;
  } sfp_flags_t;
endpackage

//--- rtl/sfp_top.sv
// flagged synchronous fifo bank: storage module and port/flag logic
`timescale 1ns/1ps

// storage fifo with valid/ready on both sides
module sfp_fifo
  import sfp_pkg::*;
#(
  parameter int W = SFP_DATA_W,
  parameter int D = SFP_DEPTH,
  parameter int CW = $clog2(D + 1)
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // fill level
  output logic [CW-1:0] level
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST_C = AW'(D - 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(D);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [W-1:0] mem_reg [D];  // word storage, flip-flops
  logic [AW-1:0] wr_ptr_reg;  // next location to write
  logic [AW-1:0] rd_ptr_reg;  // location of the head word
  logic [CW-1:0] count_reg;  // words held
  wire push = in_valid && in_ready && ce;  // accepted write
  wire pop = out_valid && out_ready && ce;  // accepted read
  wire [AW-1:0] wr_ptr_next = (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + PTR_ONE;
  wire [AW-1:0] rd_ptr_next = (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + PTR_ONE;

  // full refuses, so a stalled drain really backs up the source
  assign in_ready = (count_reg != DEPTH_C);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = count_reg;

  // one storage word per entry, written only when the pointer points at it
  genvar gi;
  generate
    for (gi = 0; gi < D; gi++)
    begin : g_word
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mem_reg[gi] <= '0;
        else if (push && (wr_ptr_reg == AW'(gi)))
          mem_reg[gi] <= in_data;
      end
    end
  endgenerate

  // pointers and count; reset returns both pointers to the first location
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_next;
      if (pop)
        rd_ptr_reg <= rd_ptr_next;
      if (push && !pop)
        count_reg <= count_reg + CNT_ONE;
      else if (pop && !push)
        count_reg <= count_reg - CNT_ONE;
    end
  end
endmodule

module sfp_top
  import sfp_pkg::*;
#(
  parameter int DATA_W = SFP_DATA_W,
  parameter int DEPTH = SFP_DEPTH
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // write port
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic primary_write_gate_n,
  input wire logic second_wr_en_or_offset_load,
  // read port
  input wire logic read_gate_one_n,
  input wire logic read_gate_two_n,
  input wire logic output_drive_n,
  output logic [DATA_W-1:0] read_data_out,
  output logic read_data_oe_n,
  // flags
  output logic empty_flag_n,
  output logic almost_empty_flag_n,
  output logic full_flag_n,
  output logic almost_full_flag_n,
  // configuration status
  output logic dual_enable_mode
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [3:0] AE_RST_C = 4'(SFP_AE_OFF_RST);
  localparam logic [3:0] AF_RST_C = 4'(SFP_AF_OFF_RST);

  logic mode_reg;  // 1: dual write enable, 0: programmable flags
  logic mode_done_reg;  // pin level caught
  sfp_offsets_t off_reg;  // programmed offsets
  logic off_wsel_reg;  // next offset to load
  logic off_rsel_reg;  // next offset to read back
  logic [DATA_W-1:0] rdata_reg;  // registered output word
  logic fifo_ready;  // space available
  logic fifo_valid;  // word available
  logic [DATA_W-1:0] fifo_head;  // head word
  logic [CW-1:0] level;  // fill level
  sfp_flags_t flags;  // flag bundle

  // decode of the dual-function pin and the gates
  wire offset_access_n = second_wr_en_or_offset_load;
  wire secondary_write_gate = second_wr_en_or_offset_load;
  wire offset_mode = mode_done_reg && (mode_reg != SFP_MODE_DUAL) && !offset_access_n;
  wire read_req = !read_gate_one_n && !read_gate_two_n;
  wire dual_push = !primary_write_gate_n && secondary_write_gate;
  wire flag_push = !primary_write_gate_n && offset_access_n;
  wire push_req = mode_done_reg && ((mode_reg == SFP_MODE_DUAL) ? dual_push : flag_push);
  wire off_wr = offset_mode && !primary_write_gate_n && ce;
  wire off_rd = offset_mode && read_req && ce;
  wire pop_req = mode_done_reg && read_req && !offset_mode;
  wire pop = pop_req && fifo_valid && ce;
  wire [3:0] off_load_val = write_data_in[3:0];
  wire [3:0] off_rd_val = (off_rsel_reg == SFP_SEL_AE) ? off_reg.ae : off_reg.af;
  wire [CW-1:0] ae_lvl = CW'(off_reg.ae);
  wire [CW-1:0] af_lvl = DEPTH_C - CW'(off_reg.af);

  // storage; a full fifo refuses the push and keeps its contents
  sfp_fifo #(.W(DATA_W), .D(DEPTH), .CW(CW)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(push_req),
    .in_ready(fifo_ready),
    .in_data(write_data_in),
    .out_valid(fifo_valid),
    .out_ready(pop_req),
    .out_data(fifo_head),
    .level(level)
  );

  // flags from the registered level; one clock, so both ports update on it
  assign flags.empty_n = (level != '0);
  assign flags.almost_empty_n = (level > ae_lvl);
  assign flags.full_n = fifo_ready;
  assign flags.almost_full_n = (level < af_lvl);
  assign empty_flag_n = flags.empty_n;
  assign almost_empty_flag_n = flags.almost_empty_n;
  assign full_flag_n = flags.full_n;
  assign almost_full_flag_n = flags.almost_full_n;
  assign read_data_out = rdata_reg;
  assign read_data_oe_n = output_drive_n;
  assign dual_enable_mode = mode_reg;

  // mode strap: async reset may only load a constant, so catch at release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= SFP_MODE_DUAL;
      mode_done_reg <= 1'b0;
    end
    else if (ce && !mode_done_reg)
    begin
      mode_reg <= second_wr_en_or_offset_load;
      mode_done_reg <= 1'b1;
    end
  end

  // offset loads alternate almost-empty then almost-full
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      off_reg <= '{ae: AE_RST_C, af: AF_RST_C};
      off_wsel_reg <= SFP_SEL_AE;
    end
    else if (off_wr)
    begin
      if (off_wsel_reg == SFP_SEL_AE)
        off_reg.ae <= off_load_val;
      else
        off_reg.af <= off_load_val;
      off_wsel_reg <= ~off_wsel_reg;
    end
  end

  // output word: next fifo word on a read, or offset readback
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
      off_rsel_reg <= SFP_SEL_AE;
    end
    else if (off_rd)
    begin
      rdata_reg <= DATA_W'(off_rd_val);
      off_rsel_reg <= ~off_rsel_reg;
    end
    else if (pop)
      rdata_reg <= fifo_head;
  end

  // checks
  property p_full_blocks;
    @(posedge clk) disable iff (!rst_n)
    (!full_flag_n && !read_req) |=> !full_flag_n && $stable(level);
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("write taken while full");

  property p_empty_blocks;
    @(posedge clk) disable iff (!rst_n)
    // offset readback may change the output word while empty, so leave it out
    (!empty_flag_n && !push_req && !off_rd) |=> $stable(rdata_reg) && !empty_flag_n;
  endproperty
  a_empty_blocks: assert property (p_empty_blocks) else $error("read taken while empty");

  property p_read_word;
    @(posedge clk) disable iff (!rst_n)
    (ce && pop_req && empty_flag_n) |=> read_data_out == $past(fifo_head);
  endproperty
  a_read_word: assert property (p_read_word) else $error("read word wrong");

  property p_dual_write;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_done_reg && mode_reg && full_flag_n && !read_req
      && !(dual_push)) |=> $stable(level);
  endproperty
  a_dual_write: assert property (p_dual_write) else $error("write without both gates");

  property p_flag_write;
    @(posedge clk) disable iff (!rst_n)
    (ce && mode_done_reg && !mode_reg && flag_push && full_flag_n && !read_req)
      |=> level == $past(level) + CW'(1);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("gate one write lost");

  property p_empty_flag;
    @(posedge clk) disable iff (!rst_n)
    empty_flag_n == (level != '0);
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");

  property p_ae_flag;
    @(posedge clk) disable iff (!rst_n)
    almost_empty_flag_n == (level > CW'(off_reg.ae));
  endproperty
  a_ae_flag: assert property (p_ae_flag) else $error("almost-empty flag wrong");

  property p_af_flag;
    @(posedge clk) disable iff (!rst_n)
    almost_full_flag_n == (level < (DEPTH_C - CW'(off_reg.af)));
  endproperty
  a_af_flag: assert property (p_af_flag) else $error("almost-full flag wrong");

  property p_full_flag;
    @(posedge clk) disable iff (!rst_n)
    full_flag_n == (level != DEPTH_C);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

  property p_oe;
    @(posedge clk) disable iff (!rst_n)
    read_data_oe_n == output_drive_n;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");

  property p_mode_hold;
    @(posedge clk) disable iff (!rst_n)
    mode_done_reg |=> mode_done_reg && $stable(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after reset");

  property p_off_hold;
    @(posedge clk) disable iff (!rst_n)
    !off_wr |=> $stable(off_reg);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("offset changed unloaded");
endmodule

//--- sim/sfp_far_model.sv
// far-side model: write pin level and the read port wire
`timescale 1ns/1ps
module sfp_far_model
  import sfp_pkg::*;
(
  // producer controls
  input wire logic hold,
  input wire logic strap,
  input wire logic g2,
  input wire logic ld_n,
  // read port from the device
  input wire logic [SFP_DATA_W-1:0] q,
  input wire logic q_oe_n,
  // shared data wire and dual pin
  output wire [SFP_DATA_W-1:0] bus,
  output logic pin
);
  // strap held through the capture edge, then gate two or load control
  assign pin = hold ? strap : (strap ? g2 : ld_n);
  // no pull on the wire, so a released bus floats
  assign bus = q_oe_n ? {SFP_DATA_W{1'bz}} : q;
endmodule

//--- sim/sfp_tb_top.sv
// self-checking bench for the flagged fifo bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module sfp_tb_top
  import sfp_pkg::*;
;
  // stimulus, all driven at the falling edge
  logic clk = 0, rst_n = 0, g1_n = 1, g2 = 0, r1_n = 1, r2_n = 1, oe_n = 0;
  logic hold = 1, strap = 1, ld_n = 1, pin;
  // clock enable, drawn at random only while ce_mix is set
  logic ce = 1, ce_mix = 0;
  logic [SFP_DATA_W-1:0] wd = 0;
  // device outputs and the shared wire
  logic [SFP_DATA_W-1:0] q, last;
  logic q_oe_n, ef_n, ae_n, ff_n, af_n, mode;
  wire [SFP_DATA_W-1:0] bus;
  // reference contents and offsets
  logic [SFP_DATA_W-1:0] fifo[$];
  int off[2];
  int wk, rk, errors = 0, n_tests = 0, seed = 32'h699d;

  // free-running 8 ns clock
  always #4 clk = ~clk;

  sfp_top sfp_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .write_data_in(wd),
    .primary_write_gate_n(g1_n), .second_wr_en_or_offset_load(pin),
    .read_gate_one_n(r1_n), .read_gate_two_n(r2_n), .output_drive_n(oe_n),
    .read_data_out(q), .read_data_oe_n(q_oe_n), .empty_flag_n(ef_n),
    .almost_empty_flag_n(ae_n), .full_flag_n(ff_n), .almost_full_flag_n(af_n),
    .dual_enable_mode(mode));
  sfp_far_model sfp_far_model_inst (.hold(hold), .strap(strap), .g2(g2), .ld_n(ld_n),
    .q(q), .q_oe_n(q_oe_n), .bus(bus), .pin(pin));

  // verdict and end of run
  task end_of_test;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // flags and outputs against the reference level
  task flags;
    int n;
    n = fifo.size();
    `CHK("empty", n != 0, ef_n)
    `CHK("aempty", !(n <= off[0]), ae_n)
    `CHK("full", n != SFP_DEPTH, ff_n)
    `CHK("afull", !(n >= SFP_DEPTH - off[1]), af_n)
    `CHK("data", last, q)
    `CHK("oe", oe_n, q_oe_n)
    `CHK("bus", oe_n ? {SFP_DATA_W{1'bz}} : last, bus)
  endtask

  // one clock of requests; begins and ends at a falling edge
  task step(input logic w1n, input logic w2, input logic a_n, input logic b_n,
            input logic [SFP_DATA_W-1:0] d);
    logic wok, rok, ld;
    g1_n = w1n;
    g2 = w2;
    r1_n = a_n;
    r2_n = b_n;
    wd = d;
    oe_n = 1'($random(seed));
    ce = ce_mix ? 1'($random(seed)) : 1'b1;
    // a low clock enable freezes the fifo, offsets and output word (the output enable still follows), so no request is taken
    ld = ce && !strap && !ld_n && !hold;
    // refused when full or empty, judged on the level before the edge
    wok = ce && !hold && !w1n && (strap ? w2 : ld_n) && fifo.size() < SFP_DEPTH;
    rok = ce && !hold && !ld && !a_n && !b_n && fifo.size() > 0;
    @(posedge clk);
    // readback shows the offset held before this edge's load
    if (ld && !a_n && !b_n)
    begin
      last = SFP_DATA_W'(off[rk]);
      rk ^= 1;
    end
    // offsets alternate almost-empty then almost-full
    if (ld && !w1n)
    begin
      off[wk] = int'(d[3:0]);
      wk ^= 1;
    end
    if (rok)
      last = fifo.pop_front();
    if (wok)
      fifo.push_back(d);
    @(negedge clk);
    flags();
  endtask

  // reset with a strap level, then the capture edge with no request
  task reset_to(input logic s);
    strap = s;
    hold = 1;
    ce_mix = 0;
    rst_n = 0;
    fifo.delete();
    off = '{SFP_AE_OFF_RST, SFP_AF_OFF_RST};
    wk = 0;
    rk = 0;
    last = 0;
    repeat (5) @(negedge clk);
    `CHK("rst_flags", 4'h3, {ef_n, ae_n, ff_n, af_n})
    rst_n = 1;
    step(1, 0, 1, 1, 0);
    hold = 0;
    `CHK("mode", s, mode)
  endtask

  // main sequence: flag mode, then dual mode with a random mix, then a final reset
  initial
  begin
    reset_to(1'b0);
    ld_n = 0;
    step(0, 0, 1, 1, 9'h002);
    step(0, 0, 1, 1, 9'h003);
    repeat (2) step(1, 0, 0, 0, 0);
    ld_n = 1;
    // gate one alone fills past full, second gate level ignored
    repeat (10) step(0, 1'($random(seed)), 1, 1, 9'($random(seed)));
    repeat (10) step(1, 0, 0, 0, 0);
    reset_to(1'b1);
    repeat (10) step(0, 1, 1, 1, 9'($random(seed)));
    repeat (10) step(1, 0, 0, 0, 0);
    // random mix, including one read gate alone, gate two low and enable low
    ce_mix = 1;
    repeat (300) step(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                      1'($random(seed)), 9'($random(seed)));
    reset_to(1'b1);
    end_of_test();
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule
